/* File: include/dsp_pin_consts.svh */
// Purpose: Named offsets, field positions, reset values and counts for the pin control block
// Assumes: APB with 32-bit data, byte addresses
// Notes: Definitions only
`ifndef DSP_PIN_CONSTS_SVH
`define DSP_PIN_CONSTS_SVH

// ----------------------------------------
// Core restart
// ----------------------------------------
`define RST_VECTOR 16'hFF80
`define ROM_BASE 16'hC000
`define MODE_RST 1'b1
`define ST1_RST 16'h0000

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_ST1 8'h04
`define OFF_PMODE 8'h08
`define OFF_BRANCH 8'h0C
`define OFF_XBUS 8'h10
`define OFF_STATUS 8'h14
`define OFF_PC 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_SET_BIT 0
`define CTRL_CLR_BIT 1
`define PMODE_MP_BIT 0
`define BR_XC_BIT 0
`define XBUS_ADDR_MSB 15
`define XBUS_SPACE_LSB 16
`define XBUS_SPACE_MSB 17
`define ST_RUN_BIT 0
`define ST_MODE_BIT 1
`define ST_XF_BIT 2
`define ST_HOLD_BIT 3
`define ST_BUSY_BIT 4
`define ST_BR_DONE_BIT 5
`define ST_BR_TAKEN_BIT 6
`define ST_BIO_BIT 7

// ----------------------------------------
// Pipeline and bus timing in machine cycles
// ----------------------------------------
`define DEC_STAGE 2'h1
`define RD_STAGE 2'h2
`define STRB_CYC 2'h2

`endif

/* File: include/dsp_pin_pkg.sv */
// Purpose: Types shared by the pin control block
// Assumes: Nothing
// Notes: Constants live in the consts header
package dsp_pin_pkg;

   // External space being accessed
   typedef enum logic [1:0] {
      SPACE_DATA = 2'b00,
      SPACE_PROG = 2'b01,
      SPACE_IO = 2'b10
   } space_e;

   // External bus sequencer states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ADDR = 2'b01,
      BUS_STRB = 2'b10
   } bus_state_e;

endpackage

/* File: logic/pin_sync.sv */
// Purpose: Three-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to pclk
// Notes: Output changes only once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q, s2_q, s3_q, q_q;
   logic [W-1:0] q_d;

   // Per bit, follow stage three where stages two and three agree
   always_comb begin
      q_d = (s3_q & ~(s2_q ^ s3_q)) | (q_q & (s2_q ^ s3_q));
   end

   // Stage registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         q_q <= RST;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_q <= q_d;
      end
   end

   assign q = q_q;
endmodule

/* File: logic/ext_bus_seq.sv */
// Purpose: External access sequencer driving space selects and strobes
// Assumes: Start only while idle
// Notes: One address cycle, then strobe cycles; selects low for the whole address time
`timescale 1ns/1ns
`include "dsp_pin_consts.svh"
module ext_bus_seq (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Request
   input wire logic start,
   input wire dsp_pin_pkg::space_e space,
   input wire logic [15:0] addr,
   // Bus side
   output logic data_sel_n,
   output logic prog_sel_n,
   output logic io_sel_n,
   output logic memory_strobe_n_n,
   output logic io_strobe_n_n,
   output logic addr_valid,
   output logic [15:0] ext_addr,
   output logic busy
);
   import dsp_pin_pkg::*;

   bus_state_e state_q, state_d;
   space_e space_q, space_d;
   logic [15:0] addr_q, addr_d;
   logic [1:0] cnt_q, cnt_d;
   logic [2:0] sel_n_q, sel_n_d;
   logic memory_strobe_n_n_q, memory_strobe_n_n_d, io_strobe_n_n_q, io_strobe_n_n_d;

   // Next state, count and registered pin values
   always_comb begin
      state_d = state_q;
      space_d = space_q;
      addr_d = addr_q;
      cnt_d = cnt_q;
      case (state_q)
         BUS_IDLE: begin
            if (start) begin
               state_d = BUS_ADDR;
               space_d = space;
               addr_d = addr;
            end
         end
         BUS_ADDR: begin
            state_d = BUS_STRB;
            cnt_d = `STRB_CYC;
         end
         BUS_STRB: begin
            cnt_d = cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
               state_d = BUS_IDLE;
            end
         end
         default: state_d = BUS_IDLE;
      endcase
      // Only the accessed space goes low, and only while address is valid
      sel_n_d = 3'h7;
      if (state_d != BUS_IDLE) begin
         case (space_d)
            SPACE_DATA: sel_n_d = 3'h6;
            SPACE_PROG: sel_n_d = 3'h5;
            SPACE_IO: sel_n_d = 3'h3;
            default: sel_n_d = 3'h7;
         endcase
      end
      memory_strobe_n_n_d = !((state_d == BUS_STRB) && (space_d != SPACE_IO));
      io_strobe_n_n_d = !((state_d == BUS_STRB) && (space_d == SPACE_IO));
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= BUS_IDLE;
         space_q <= SPACE_DATA;
         addr_q <= 16'h0000;
         cnt_q <= 2'h0;
         sel_n_q <= 3'h7;
         memory_strobe_n_n_q <= 1'b1;
         io_strobe_n_n_q <= 1'b1;
      end else begin
         state_q <= state_d;
         space_q <= space_d;
         addr_q <= addr_d;
         cnt_q <= cnt_d;
         sel_n_q <= sel_n_d;
         memory_strobe_n_n_q <= memory_strobe_n_n_d;
         io_strobe_n_n_q <= io_strobe_n_n_d;
      end
   end

   assign data_sel_n = sel_n_q[0];
   assign prog_sel_n = sel_n_q[1];
   assign io_sel_n = sel_n_q[2];
   assign memory_strobe_n_n = memory_strobe_n_n_q;
   assign io_strobe_n_n = io_strobe_n_n_q;
   assign addr_valid = (state_q != BUS_IDLE);
   assign ext_addr = addr_q;
   assign busy = (state_q != BUS_IDLE);
endmodule

/* File: logic/dsp_pin_ctrl.sv */
// Purpose: Reset, ROM map mode, branch input, flag output and bus select pins of a DSP
// Assumes: pclk 20 MHz is the machine cycle; APB slave with zero wait states
// Notes: Pin inputs pass three-flop synchronisers
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "dsp_pin_consts.svh"
module dsp_pin_ctrl (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pin inputs
   input wire logic reset_in_n,
   input wire logic rom_map_select,
   input wire logic branch_condition_in,
   input wire logic output_float_n,
   input wire logic bus_hold_req_n,
   // Flag output
   output logic external_flag_out,
   output logic external_flag_oe,
   // Space selects and strobes
   output logic data_space_select_n,
   output logic program_space_select_n,
   output logic io_space_select_n,
   output logic space_select_oe,
   output logic memory_strobe_n,
   output logic io_strobe_n,
   output logic strobe_oe,
   output logic [15:0] ext_addr,
   output logic ext_addr_oe,
   output logic bus_hold_ack_n,
   // Core view
   output logic [15:0] program_counter,
   output logic core_running,
   output logic rom_mapped,
   output logic rom_fetch
);
   import dsp_pin_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Offset decode, shared by read and write paths
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `OFF_CTRL) || (a == `OFF_ST1) || (a == `OFF_PMODE) ||
         (a == `OFF_BRANCH) || (a == `OFF_XBUS) || (a == `OFF_STATUS) || (a == `OFF_PC);
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic rst_pin_s, map_pin_s, bio_s, float_n_s, hold_req_n_s;

   // Core reset pin starts asserted so the core never runs before the pin is seen
   pin_sync #(.W(5), .RST(5'h0B)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({reset_in_n, rom_map_select, branch_condition_in, output_float_n, bus_hold_req_n}),
      .q({rst_pin_s, map_pin_s, bio_s, float_n_s, hold_req_n_s})
   );

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic wr_acc, setup;
   logic bus_busy, xbus_start, xbus_err;
   logic hold_q, hold_d;
   logic run_q, run_d;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite && is_mapped(paddr);
   // External access refused while busy, in hold or in reset
   assign xbus_err = (paddr == `OFF_XBUS) && pwrite && (bus_busy || hold_q || !run_q);
   assign xbus_start = wr_acc && (paddr == `OFF_XBUS) && !xbus_err;
   assign pready = 1'b1;
   assign pslverr = psel && penable && (!is_mapped(paddr) || xbus_err);

   // ----------------------------------------
   // Core reset and fetch model
   // ----------------------------------------
   logic [15:0] pc_q, pc_d;

   // Halt and hold the vector while reset pin is low, then count fetches
   always_comb begin
      run_d = rst_pin_s;
      pc_d = pc_q;
      if (!rst_pin_s) begin
         pc_d = `RST_VECTOR;
      end else if (run_q) begin
         pc_d = pc_q + 16'h0001;
      end
   end

   // Core registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
         pc_q <= `RST_VECTOR;
      end else begin
         run_q <= run_d;
         pc_q <= pc_d;
      end
   end

   // ----------------------------------------
   // ROM map mode
   // ----------------------------------------
   logic mode_q, mode_d;

   // Pin copied only during reset; software may change it afterwards
   always_comb begin
      mode_d = mode_q;
      if (!rst_pin_s) begin
         mode_d = map_pin_s;
      end else if (wr_acc && (paddr == `OFF_PMODE)) begin
         mode_d = pwdata[`PMODE_MP_BIT];
      end
   end

   // Mode register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `MODE_RST;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign rom_mapped = !mode_q;
   assign rom_fetch = !mode_q && (pc_q >= `ROM_BASE);

   // ----------------------------------------
   // Branch condition test
   // ----------------------------------------
   logic [1:0] br_cnt_q, br_cnt_d;
   logic br_xc_q, br_xc_d;
   logic br_done_q, br_done_d, br_taken_q, br_taken_d;

   // Sample at decode stage for XC-type tests, at read stage otherwise
   always_comb begin
      br_cnt_d = br_cnt_q;
      br_xc_d = br_xc_q;
      br_done_d = br_done_q;
      br_taken_d = br_taken_q;
      if (wr_acc && (paddr == `OFF_BRANCH) && run_q) begin
         br_cnt_d = 2'h1;
         br_xc_d = pwdata[`BR_XC_BIT];
         br_done_d = 1'b0;
      end else if (br_cnt_q != 2'h0) begin
         if (br_cnt_q == (br_xc_q ? `DEC_STAGE : `RD_STAGE)) begin
            br_taken_d = !bio_s;
            br_done_d = 1'b1;
            br_cnt_d = 2'h0;
         end else begin
            br_cnt_d = br_cnt_q + 2'h1;
         end
      end
      if (!run_q) begin
         br_cnt_d = 2'h0;
      end
   end

   // Branch test registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         br_cnt_q <= 2'h0;
         br_xc_q <= 1'b0;
         br_done_q <= 1'b0;
         br_taken_q <= 1'b0;
      end else begin
         br_cnt_q <= br_cnt_d;
         br_xc_q <= br_xc_d;
         br_done_q <= br_done_d;
         br_taken_q <= br_taken_d;
      end
   end

   // ----------------------------------------
   // External flag and status word one
   // ----------------------------------------
   logic xf_q, xf_d;
   logic [15:0] st1_q, st1_d;

   // Set op wins over clear op in one write; status word load clears flag
   always_comb begin
      xf_d = xf_q;
      st1_d = st1_q;
      if (!rst_pin_s) begin
         xf_d = 1'b1;
      end else if (wr_acc && (paddr == `OFF_CTRL)) begin
         if (pwdata[`CTRL_SET_BIT]) begin
            xf_d = 1'b1;
         end else if (pwdata[`CTRL_CLR_BIT]) begin
            xf_d = 1'b0;
         end
      end else if (wr_acc && (paddr == `OFF_ST1)) begin
         st1_d = pwdata[15:0];
         xf_d = 1'b0;
      end
   end

   // Flag registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xf_q <= 1'b1;
         st1_q <= `ST1_RST;
      end else begin
         xf_q <= xf_d;
         st1_q <= st1_d;
      end
   end

   assign external_flag_out = xf_q;
   assign external_flag_oe = float_n_s;

   // ----------------------------------------
   // Bus hold and external access
   // ----------------------------------------
   logic addr_valid;

   // Enter hold only between accesses; leave once request drops
   always_comb begin
      hold_d = hold_q;
      if (!hold_req_n_s && !bus_busy) begin
         hold_d = 1'b1;
      end else if (hold_req_n_s) begin
         hold_d = 1'b0;
      end
   end

   // Hold register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
      end
   end

   ext_bus_seq u_seq (
      .clk(pclk),
      .rst_n(presetn),
      .start(xbus_start),
      .space(space_e'(pwdata[`XBUS_SPACE_MSB:`XBUS_SPACE_LSB])),
      .addr(pwdata[`XBUS_ADDR_MSB:0]),
      .data_sel_n(data_space_select_n),
      .prog_sel_n(program_space_select_n),
      .io_sel_n(io_space_select_n),
      .memory_strobe_n_n(memory_strobe_n),
      .io_strobe_n_n(io_strobe_n),
      .addr_valid(addr_valid),
      .ext_addr(ext_addr),
      .busy(bus_busy)
   );

   // Float selects, strobes and address in hold or when float input low
   assign space_select_oe = float_n_s && !hold_q;
   assign strobe_oe = float_n_s && !hold_q;
   assign ext_addr_oe = float_n_s && !hold_q && addr_valid;
   assign bus_hold_ack_n = !hold_q;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [31:0] rdata_q, rdata_d;

   // Capture read data in the setup cycle
   always_comb begin
      rdata_d = rdata_q;
      if (setup && !pwrite) begin
         rdata_d = 32'h0000_0000;
         case (paddr)
            `OFF_ST1: rdata_d[15:0] = st1_q;
            `OFF_PMODE: rdata_d[`PMODE_MP_BIT] = mode_q;
            `OFF_BRANCH: rdata_d[`BR_XC_BIT] = br_xc_q;
            `OFF_XBUS: rdata_d[15:0] = ext_addr;
            `OFF_STATUS: begin
               rdata_d[`ST_RUN_BIT] = run_q;
               rdata_d[`ST_MODE_BIT] = mode_q;
               rdata_d[`ST_XF_BIT] = xf_q;
               rdata_d[`ST_HOLD_BIT] = hold_q;
               rdata_d[`ST_BUSY_BIT] = bus_busy;
               rdata_d[`ST_BR_DONE_BIT] = br_done_q;
               rdata_d[`ST_BR_TAKEN_BIT] = br_taken_q;
               rdata_d[`ST_BIO_BIT] = bio_s;
            end
            `OFF_PC: rdata_d[15:0] = pc_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;
   assign program_counter = pc_q;
   assign core_running = run_q;
endmodule

/* File: test/pin_ctrl_assertions.sv */
// Purpose: Concurrent checks on the pin control block ports
// Assumes: Space code 3 never used; selects reset high
// Notes: Bound into every dsp_pin_ctrl instance
`timescale 1ns/1ns
`include "dsp_pin_consts.svh"
module pin_ctrl_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Watched pins
   input wire logic output_float_n,
   input wire logic external_flag_oe,
   input wire logic data_space_select_n,
   input wire logic program_space_select_n,
   input wire logic io_space_select_n,
   input wire logic space_select_oe,
   input wire logic memory_strobe_n,
   input wire logic io_strobe_n,
   input wire logic strobe_oe,
   input wire logic ext_addr_oe,
   input wire logic bus_hold_ack_n,
   input wire logic [15:0] program_counter,
   input wire logic core_running,
   input wire logic rom_mapped,
   input wire logic rom_fetch
);
   logic sel_low;
   // Some space select is active
   assign sel_low = !(data_space_select_n && program_space_select_n && io_space_select_n);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_one_select: assert property (
      $onehot0({!data_space_select_n, !program_space_select_n, !io_space_select_n}))
      else $error("two selects low");
   a_sel_addr: assert property (space_select_oe |-> sel_low == ext_addr_oe)
      else $error("select and address valid differ");
   a_sel_span: assert property ($rose(sel_low) |-> sel_low [*3] ##1 !sel_low)
      else $error("select span wrong");
   a_mem_strobe: assert property (
      !memory_strobe_n |-> !data_space_select_n || !program_space_select_n)
      else $error("memory strobe without memory access");
   a_io_strobe: assert property (!io_strobe_n |-> !io_space_select_n)
      else $error("io strobe without io access");
   a_hold_float: assert property (!bus_hold_ack_n |-> !space_select_oe && !strobe_oe)
      else $error("bus pins driven in hold");
   a_float_pins: assert property (
      $fell(output_float_n) ##1 !output_float_n [*5] |-> !external_flag_oe && !space_select_oe)
      else $error("pins driven while float requested");
   a_pc_halt: assert property (!core_running |-> program_counter == `RST_VECTOR)
      else $error("pc not at vector while halted");
   a_pc_start: assert property ($rose(core_running) |->
      program_counter == `RST_VECTOR ##1 program_counter == `RST_VECTOR + 16'h0001)
      else $error("fetch does not start at vector");
   a_rom_fetch: assert property (
      rom_fetch == (rom_mapped && program_counter >= `ROM_BASE))
      else $error("rom fetch decode wrong");
endmodule
bind dsp_pin_ctrl pin_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn),
   .output_float_n(output_float_n), .external_flag_oe(external_flag_oe),
   .data_space_select_n(data_space_select_n), .program_space_select_n(program_space_select_n),
   .io_space_select_n(io_space_select_n), .space_select_oe(space_select_oe),
   .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n), .strobe_oe(strobe_oe),
   .ext_addr_oe(ext_addr_oe), .bus_hold_ack_n(bus_hold_ack_n),
   .program_counter(program_counter), .core_running(core_running),
   .rom_mapped(rom_mapped), .rom_fetch(rom_fetch));

/* File: test/ext_space_model.sv */
// Purpose: External memory, I/O and outside master seen by the block
// Assumes: Selects and strobes active low
// Notes: Records accesses; asks for the bus on command
`timescale 1ns/1ns
module ext_space_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus pins from the block
   input wire logic [2:0] sel_n,
   input wire logic memory_strobe_n,
   input wire logic io_strobe_n,
   input wire logic [15:0] ext_addr,
   // Outside master
   input wire logic want_hold,
   output logic bus_hold_req_n,
   // Observed traffic
   output logic [2:0] last_sel_n,
   output logic [15:0] last_addr,
   output logic [7:0] mem_cycles,
   output logic [7:0] io_cycles
);
   // Outside master requests the bus while want_hold is high
   assign bus_hold_req_n = !want_hold;
   // Latch the active select and address; count strobe cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_sel_n <= 3'h7;
         last_addr <= 16'h0000;
         mem_cycles <= 8'h00;
         io_cycles <= 8'h00;
      end else begin
         if (sel_n != 3'h7) begin
            last_sel_n <= sel_n;
            last_addr <= ext_addr;
         end
         mem_cycles <= mem_cycles + {7'h00, !memory_strobe_n};
         io_cycles <= io_cycles + {7'h00, !io_strobe_n};
      end
   end
endmodule

/* File: test/dsp_pin_ctrl_tb.sv */
// Purpose: Self-checking bench for the pin control block
// Assumes: Zero wait APB; pins seen after the synchronisers
// Notes: Expectations follow the register map constants
`timescale 1ns/1ns
`include "dsp_pin_consts.svh"
module dsp_pin_ctrl_tb;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, want_hold, hold_req_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic reset_in_n, rom_map_select, branch_condition_in, output_float_n, perr;
   logic flag, flag_oe, ds_n, ps_n, is_n, sel_oe, memory_strobe_n_n, io_strobe_n_n, strb_oe, addr_oe, ack_n;
   logic [15:0] ext_addr, pc, last_addr;
   logic run, rom_mapped, rom_fetch;
   logic [2:0] last_sel_n;
   logic [7:0] mem_c, io_c, mem0, io0;
   int failures = 0;
   int samples_checked = 0;
   logic [7:0] fa[4] = '{`OFF_CTRL, `OFF_CTRL, `OFF_CTRL, `OFF_ST1};
   logic [31:0] fd[4] = '{32'h1, 32'h2, 32'h3, 32'h1234};
   logic fe[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   always #25 pclk = ~pclk;

   dsp_pin_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_in_n(reset_in_n), .rom_map_select(rom_map_select),
      .branch_condition_in(branch_condition_in), .output_float_n(output_float_n),
      .bus_hold_req_n(hold_req_n), .external_flag_out(flag), .external_flag_oe(flag_oe),
      .data_space_select_n(ds_n), .program_space_select_n(ps_n), .io_space_select_n(is_n),
      .space_select_oe(sel_oe), .memory_strobe_n(memory_strobe_n_n), .io_strobe_n(io_strobe_n_n),
      .strobe_oe(strb_oe), .ext_addr(ext_addr), .ext_addr_oe(addr_oe), .bus_hold_ack_n(ack_n),
      .program_counter(pc), .core_running(run), .rom_mapped(rom_mapped), .rom_fetch(rom_fetch));

   ext_space_model u_far (.pclk(pclk), .presetn(presetn), .sel_n({is_n, ps_n, ds_n}),
      .memory_strobe_n(memory_strobe_n_n), .io_strobe_n(io_strobe_n_n), .ext_addr(ext_addr),
      .want_hold(want_hold), .bus_hold_req_n(hold_req_n), .last_sel_n(last_sel_n),
      .last_addr(last_addr), .mem_cycles(mem_c), .io_cycles(io_c));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer: setup, then access until pready
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] m, input logic [31:0] e, input logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) chk(32'h0, 32'h1);
      rdat = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!w) chk(rdat & m, e);
      chk({31'h0, perr}, {31'h0, er});
   endtask

   task automatic results;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {reset_in_n, rom_map_select, want_hold} = 3'b000;
      {branch_condition_in, output_float_n} = 2'b11;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      acc(1'b0, `OFF_PC, 32'h0, 32'hFFFF, 32'hFF80, 1'b0);
      acc(1'b0, `OFF_STATUS, 32'h0, 32'h7, 32'h4, 1'b0);
      @(negedge pclk);
      chk({31'h0, rom_mapped}, 32'h1);
      @(posedge pclk);
      reset_in_n <= 1'b1;
      repeat (8) @(posedge pclk);
      rom_map_select <= 1'b1;
      repeat (8) @(negedge pclk);
      chk({29'h0, run, rom_mapped, rom_fetch}, 32'h7);
      acc(1'b1, `OFF_PMODE, 32'h1, 32'h0, 32'h0, 1'b0);
      @(negedge pclk);
      chk({31'h0, rom_mapped}, 32'h0);
      acc(1'b0, `OFF_PMODE, 32'h0, 32'h1, 32'h1, 1'b0);
      // Flag set, clear, set winning over clear, status word load
      foreach (fa[i]) begin
         acc(1'b1, fa[i], fd[i], 32'h0, 32'h0, 1'b0);
         @(negedge pclk);
         chk({31'h0, flag}, {31'h0, fe[i]});
      end
      acc(1'b0, `OFF_ST1, 32'h0, 32'hFFFF, 32'h1234, 1'b0);
      // Both test kinds with the branch input true and false
      for (int k = 0; k < 4; k++) begin
         branch_condition_in <= k[1];
         repeat (6) @(posedge pclk);
         acc(1'b1, `OFF_BRANCH, {31'h0, k[0]}, 32'h0, 32'h0, 1'b0);
         repeat (4) @(posedge pclk);
         acc(1'b0, `OFF_STATUS, 32'h0, 32'hE0, {24'h0, k[1], !k[1], 6'h20}, 1'b0);
         acc(1'b0, `OFF_BRANCH, 32'h0, 32'h1, {31'h0, k[0]}, 1'b0);
      end
      // Pin flips as the test is written: decode kind sees old level, read kind new
      for (int j = 1; j >= 0; j--) begin
         branch_condition_in <= !j[0];
         acc(1'b1, `OFF_BRANCH, {31'h0, j[0]}, 32'h0, 32'h0, 1'b0);
         repeat (4) @(posedge pclk);
         acc(1'b0, `OFF_STATUS, 32'h0, 32'hE0, {24'h0, !j[0], 7'h20}, 1'b0);
      end
      // One access per space, a second one refused while busy
      for (int s = 0; s < 3; s++) begin
         mem0 = mem_c;
         io0 = io_c;
         acc(1'b1, `OFF_XBUS, {14'h0, s[1:0], 16'hA530 + s[15:0]}, 32'h0, 32'h0, 1'b0);
         acc(1'b1, `OFF_XBUS, 32'h0, 32'h0, 32'h0, 1'b1);
         repeat (4) @(negedge pclk);
         chk({29'h0, last_sel_n}, {29'h0, ~(3'b001 << s)});
         chk({16'h0, last_addr}, 32'hA530 + s);
         chk({24'h0, mem_c - mem0}, (s < 2) ? 32'h2 : 32'h0);
         chk({24'h0, io_c - io0}, (s == 2) ? 32'h2 : 32'h0);
         acc(1'b0, `OFF_XBUS, 32'h0, 32'hFFFF, 32'hA530 + s, 1'b0);
      end
      acc(1'b0, 8'h1C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
      // Outside master takes the bus
      want_hold <= 1'b1;
      for (int n = 0; n < 20 && ack_n !== 1'b0; n++) @(negedge pclk);
      chk({30'h0, sel_oe, strb_oe}, 32'h0);
      acc(1'b1, `OFF_XBUS, 32'h1, 32'h0, 32'h0, 1'b1);
      want_hold <= 1'b0;
      output_float_n <= 1'b0;
      repeat (8) @(negedge pclk);
      chk({29'h0, flag_oe, sel_oe, strb_oe}, 32'h0);
      @(posedge pclk);
      output_float_n <= 1'b1;
      repeat (8) @(negedge pclk);
      chk({29'h0, flag_oe, sel_oe, strb_oe}, 32'h7);
      acc(1'b1, `OFF_CTRL, 32'h2, 32'h0, 32'h0, 1'b0);
      reset_in_n <= 1'b0;
      repeat (8) @(negedge pclk);
      chk({29'h0, flag, rom_mapped, run}, 32'h4);
      @(posedge pclk);
      reset_in_n <= 1'b1;
      repeat (8) @(posedge pclk);
      results();
   end

   // Watchdog well beyond the test length
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      results();
   end
endmodule
